// File: hdl/scan_test_port.sv
// scan test access port with emulator pins and global output-disable
module scan_test_port
  import scan_port_pkg::*;
#(
  parameter logic [DR_WIDTH-1:0] ID_VALUE = ID_VALUE_DEFAULT // arbitrary identity
) (
  input wire logic clk, // system clock
  input wire logic sys_rst, // synchronous reset, active high
  input wire logic tck, // test clock from the scan controller
  input wire logic test_reset_n, // high: scan control, low: functional
  input wire logic tms, // test mode select
  input wire logic tdi, // test data in
  output logic tdo, // test data out
  output logic tdo_oe, // high while tdo is driven
  input wire logic emulator_pin_zero_i, // emulator pin zero level
  output logic emulator_pin_zero_o, // emulator pin zero drive value
  output logic emulator_pin_zero_oe, // emulator pin zero drive enable
  input wire logic emulator_pin_one_output_disable_i, // pin one level
  output logic emulator_pin_one_output_disable_o, // pin one drive value
  output logic emulator_pin_one_output_disable_oe, // pin one drive enable
  input wire logic emu_irq_req, // device interrupt toward emulator, clk domain
  output logic scan_mode, // scan system controls the device
  output logic all_outputs_float, // every device output driver must float
  output logic emulator_pin_zero_irq, // interrupt from emulator on pin zero
  output logic emu1_irq // interrupt from emulator on pin one
);

  tap_state_t state;
  logic [IR_WIDTH-1:0] ir;
  logic [IR_WIDTH-1:0] ir_shift;
  logic [DR_WIDTH-1:0] dr_shift;
  logic bypass;
  logic [EMU_CTRL_WIDTH-1:0] emu_ctrl;
  logic [PIN_SYNC_WIDTH-1:0] pins_clk;
  logic [1:0] emu_pins_tck;
  logic irq_req_tck;
  logic shifting;
  logic next_tdo;

  // clk-domain view of the asynchronous pins
  level_sync #(
    .WIDTH(PIN_SYNC_WIDTH)
  ) clk_pin_sync (
    .clk(clk),
    .rst(sys_rst),
    .async_in({emulator_pin_one_output_disable_i, emulator_pin_zero_i, test_reset_n}),
    .sync_out(pins_clk)
  );

  // tck-domain view of emulator pins and device interrupt request;
  // no reset here since the test reset is asynchronous to tck
  level_sync #(
    .WIDTH(PIN_SYNC_WIDTH)
  ) tck_pin_sync (
    .clk(tck),
    .rst(1'b0),
    .async_in({emu_irq_req, emulator_pin_one_output_disable_i, emulator_pin_zero_i}),
    .sync_out({irq_req_tck, emu_pins_tck})
  );

  tap_fsm controller (
    .tck(tck),
    .test_reset_n(test_reset_n),
    .tms(tms),
    .state(state)
  );

  assign shifting = (state == TAP_SHIFT_DR) || (state == TAP_SHIFT_IR);

  // instruction path
  always_ff @(posedge tck or negedge test_reset_n)
  begin
    if (!test_reset_n)
    begin
      ir_shift <= IR_CAPTURE_PATTERN;
      ir <= IR_IDCODE;
    end
    else
    begin
      unique case (state)
        TAP_CAPTURE_IR: ir_shift <= IR_CAPTURE_PATTERN;
        TAP_SHIFT_IR:   ir_shift <= {tdi, ir_shift[IR_WIDTH-1:1]};
        TAP_UPDATE_IR:  ir <= ir_shift;
        TAP_RESET:      ir <= IR_IDCODE;
        default:        ir <= ir;
      endcase
    end
  end

  // data register path: bypass, identity and emulator control
  always_ff @(posedge tck or negedge test_reset_n)
  begin
    if (!test_reset_n)
    begin
      dr_shift <= '0;
      bypass <= 1'b0;
    end
    else if (state == TAP_CAPTURE_DR)
    begin
      bypass <= 1'b0;
      if (ir == IR_IDCODE)
        dr_shift <= ID_VALUE;
      else if (ir == IR_EMU_CTRL)
      begin
        dr_shift <= '0;
        dr_shift[EMULATOR_PIN_ZERO_DIR_BIT] <= emu_ctrl[EMULATOR_PIN_ZERO_DIR_BIT];
        dr_shift[EMU1_DIR_BIT] <= emu_ctrl[EMU1_DIR_BIT];
        dr_shift[EMULATOR_PIN_ZERO_VAL_BIT] <= emu_pins_tck[0];
        dr_shift[EMU1_VAL_BIT] <= emu_pins_tck[1];
      end
    end
    else if (state == TAP_SHIFT_DR)
    begin
      bypass <= tdi;
      if (ir == IR_IDCODE)
        dr_shift <= {tdi, dr_shift[DR_WIDTH-1:1]};
      else if (ir == IR_EMU_CTRL)
        dr_shift[EMU_CTRL_WIDTH-1:0] <= {tdi, dr_shift[EMU_CTRL_WIDTH-1:1]};
    end
  end

  // emulator pin direction and value are set through the scan system
  always_ff @(posedge tck or negedge test_reset_n)
  begin
    if (!test_reset_n)
      emu_ctrl <= '0;
    else if (state == TAP_UPDATE_DR && ir == IR_EMU_CTRL)
      emu_ctrl <= dr_shift[EMU_CTRL_WIDTH-1:0];
  end

  // pins only drive in scan mode; reset leaves pin one a pure input
  // so it can act as the output-disable input
  always_ff @(posedge tck or negedge test_reset_n)
  begin
    if (!test_reset_n)
    begin
      emulator_pin_zero_o <= 1'b0;
      emulator_pin_zero_oe <= 1'b0;
      emulator_pin_one_output_disable_o <= 1'b0;
      emulator_pin_one_output_disable_oe <= 1'b0;
    end
    else
    begin
      emulator_pin_zero_o <= emu_ctrl[EMULATOR_PIN_ZERO_VAL_BIT] | irq_req_tck;
      emulator_pin_zero_oe <= emu_ctrl[EMULATOR_PIN_ZERO_DIR_BIT];
      emulator_pin_one_output_disable_o <= emu_ctrl[EMU1_VAL_BIT] | irq_req_tck;
      emulator_pin_one_output_disable_oe <= emu_ctrl[EMU1_DIR_BIT];
    end
  end

  always_comb
  begin
    if (state == TAP_SHIFT_IR)
      next_tdo = ir_shift[0];
    else if (ir == IR_IDCODE || ir == IR_EMU_CTRL)
      next_tdo = dr_shift[0];
    else
      next_tdo = bypass;
  end

  // output changes on falling tck so the controller samples a settled bit;
  // test reset low also covers the output-disable case
  always_ff @(negedge tck or negedge test_reset_n)
  begin
    if (!test_reset_n)
    begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
    end
    else
    begin
      tdo <= next_tdo;
      tdo_oe <= shifting;
    end
  end

  // system-side status
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      scan_mode <= 1'b0;
      all_outputs_float <= 1'b0;
    end
    else
    begin
      scan_mode <= pins_clk[SYNC_TRST];
      all_outputs_float <= !pins_clk[SYNC_TRST] && pins_clk[SYNC_EMULATOR_PIN_ZERO]
                           && !pins_clk[SYNC_EMU1];
    end
  end

  // emulator interrupts are only meaningful under scan control;
  // in functional mode the pins serve the output-disable function
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      emulator_pin_zero_irq <= 1'b0;
      emu1_irq <= 1'b0;
    end
    else
    begin
      emulator_pin_zero_irq <= pins_clk[SYNC_TRST] && pins_clk[SYNC_EMULATOR_PIN_ZERO];
      emu1_irq <= pins_clk[SYNC_TRST] && pins_clk[SYNC_EMU1];
    end
  end

  tdo_float_a: assert property (
    @(negedge tck) disable iff (!test_reset_n)
    tdo_oe |-> $past(shifting))
    else $error("tdo driven outside a shift");

  tdo_bypass_a: assert property (
    @(negedge tck) disable iff (!test_reset_n)
    $past(state) == TAP_SHIFT_DR && $past(ir) == IR_BYPASS |-> tdo == $past(bypass))
    else $error("tdo does not follow bypass bit");

  bypass_capture_a: assert property (
    @(posedge tck) disable iff (!test_reset_n)
    state == TAP_SHIFT_DR |=> bypass == $past(tdi))
    else $error("bypass did not capture tdi");

  ir_shift_in_a: assert property (
    @(posedge tck) disable iff (!test_reset_n)
    state == TAP_SHIFT_IR |=> ir_shift[IR_WIDTH-1] == $past(tdi))
    else $error("instruction shift did not take tdi");

  emu_dir_update_a: assert property (
    @(posedge tck) disable iff (!test_reset_n)
    state == TAP_UPDATE_DR && ir == IR_EMU_CTRL
      |=> ##1 emulator_pin_zero_oe == $past(dr_shift[EMULATOR_PIN_ZERO_DIR_BIT], 2))
    else $error("emulator pin direction not set by scan");

  float_enable_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    !pins_clk[SYNC_TRST] && pins_clk[SYNC_EMULATOR_PIN_ZERO] && !pins_clk[SYNC_EMU1]
      |=> all_outputs_float)
    else $error("output-disable did not activate");

  float_cause_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    all_outputs_float |-> $past(!pins_clk[SYNC_TRST] && pins_clk[SYNC_EMULATOR_PIN_ZERO]))
    else $error("outputs floated without enabling conditions");

  float_tdo_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    all_outputs_float |-> !tdo_oe)
    else $error("tdo driven during output-disable");

  scan_handover_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    $rose(pins_clk[SYNC_TRST]) |=> scan_mode && !all_outputs_float)
    else $error("scan control not granted");

  functional_quiet_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    !pins_clk[SYNC_TRST] [*2] |-> !emulator_pin_one_output_disable_oe && !emu1_irq)
    else $error("pin one active in functional mode");

  ir_shift_out_a: assert property (
    @(negedge tck) disable iff (!test_reset_n)
    $past(state) == TAP_SHIFT_IR |-> tdo == $past(ir_shift[0]))
    else $error("tdo does not follow instruction shift");

  dr_shift_out_a: assert property (
    @(negedge tck) disable iff (!test_reset_n)
    $past(state) == TAP_SHIFT_DR && ($past(ir) == IR_IDCODE || $past(ir) == IR_EMU_CTRL)
      |-> tdo == $past(dr_shift[0]))
    else $error("tdo does not follow data shift");

  idle_quiet_a: assert property (
    @(negedge tck) disable iff (!test_reset_n)
    $past(state) == TAP_IDLE |-> !tdo_oe)
    else $error("tdo driven while idle");

  id_capture_a: assert property (
    @(posedge tck) disable iff (!test_reset_n)
    state == TAP_CAPTURE_DR && ir == IR_IDCODE |=> dr_shift == ID_VALUE)
    else $error("identity not captured");

  ir_update_a: assert property (
    @(posedge tck) disable iff (!test_reset_n)
    state == TAP_UPDATE_IR |=> ir == $past(ir_shift))
    else $error("instruction not updated");

  // raw pin seen from clk: drivers drop as soon as test reset falls
  pin_release_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    !test_reset_n |-> !emulator_pin_zero_oe && !emulator_pin_one_output_disable_oe)
    else $error("emulator pins driven in functional mode");

endmodule

// File: common/scan_port_pkg.sv
// shared constants and types for the scan test port and output-disable logic
package scan_port_pkg;

  typedef enum logic [3:0] {
    TAP_RESET      = 4'hf,
    TAP_IDLE       = 4'hc,
    TAP_SELECT_DR  = 4'h7,
    TAP_CAPTURE_DR = 4'h6,
    TAP_SHIFT_DR   = 4'h2,
    TAP_EXIT1_DR   = 4'h1,
    TAP_PAUSE_DR   = 4'h3,
    TAP_EXIT2_DR   = 4'h0,
    TAP_UPDATE_DR  = 4'h5,
    TAP_SELECT_IR  = 4'h4,
    TAP_CAPTURE_IR = 4'he,
    TAP_SHIFT_IR   = 4'ha,
    TAP_EXIT1_IR   = 4'h9,
    TAP_PAUSE_IR   = 4'hb,
    TAP_EXIT2_IR   = 4'h8,
    TAP_UPDATE_IR  = 4'hd
  } tap_state_t;

  localparam int IR_WIDTH = 4;
  localparam int DR_WIDTH = 32;
  localparam int EMU_CTRL_WIDTH = 4;

  localparam logic [IR_WIDTH-1:0] IR_IDCODE = 4'h1;
  localparam logic [IR_WIDTH-1:0] IR_EMU_CTRL = 4'h2;
  localparam logic [IR_WIDTH-1:0] IR_BYPASS = 4'hf;
  localparam logic [IR_WIDTH-1:0] IR_CAPTURE_PATTERN = 4'h1;

  // identity value is arbitrary
  localparam logic [DR_WIDTH-1:0] ID_VALUE_DEFAULT = 32'h0000_0001;

  // emulator control register layout
  localparam int EMULATOR_PIN_ZERO_DIR_BIT = 0;
  localparam int EMU1_DIR_BIT = 1;
  localparam int EMULATOR_PIN_ZERO_VAL_BIT = 2;
  localparam int EMU1_VAL_BIT = 3;

  // pin synchroniser slots
  localparam int PIN_SYNC_WIDTH = 3;
  localparam int SYNC_TRST = 0;
  localparam int SYNC_EMULATOR_PIN_ZERO = 1;
  localparam int SYNC_EMU1 = 2;

endpackage

// File: hdl/level_sync.sv
// two-flop level synchroniser, one bit per lane
module level_sync
  import scan_port_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input wire logic clk, // destination clock
  input wire logic rst, // synchronous reset, active high
  input wire logic [WIDTH-1:0] async_in, // levels from another domain
  output logic [WIDTH-1:0] sync_out // levels safe to use in clk domain
);

  logic [WIDTH-1:0] stage1;

  // stage1 feeds sync_out only
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      stage1 <= '0;
      sync_out <= '0;
    end
    else
    begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule

// File: hdl/tap_fsm.sv
// sixteen-state test access port controller
module tap_fsm
  import scan_port_pkg::*;
(
  input wire logic tck, // test clock
  input wire logic test_reset_n, // low holds the controller in reset
  input wire logic tms, // mode select, sampled on rising tck
  output tap_state_t state // current controller state
);

  tap_state_t next_state;

  always_comb
  begin
    next_state = state;
    unique case (state)
      TAP_RESET:      next_state = tms ? TAP_RESET : TAP_IDLE;
      TAP_IDLE:       next_state = tms ? TAP_SELECT_DR : TAP_IDLE;
      TAP_SELECT_DR:  next_state = tms ? TAP_SELECT_IR : TAP_CAPTURE_DR;
      TAP_CAPTURE_DR: next_state = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR:   next_state = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR:   next_state = tms ? TAP_UPDATE_DR : TAP_PAUSE_DR;
      TAP_PAUSE_DR:   next_state = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR:   next_state = tms ? TAP_UPDATE_DR : TAP_SHIFT_DR;
      TAP_UPDATE_DR:  next_state = tms ? TAP_SELECT_DR : TAP_IDLE;
      TAP_SELECT_IR:  next_state = tms ? TAP_RESET : TAP_CAPTURE_IR;
      TAP_CAPTURE_IR: next_state = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR:   next_state = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR:   next_state = tms ? TAP_UPDATE_IR : TAP_PAUSE_IR;
      TAP_PAUSE_IR:   next_state = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR:   next_state = tms ? TAP_UPDATE_IR : TAP_SHIFT_IR;
      TAP_UPDATE_IR:  next_state = tms ? TAP_SELECT_DR : TAP_IDLE;
    endcase
  end

  // mode select is a serial control stream taken on rising tck
  always_ff @(posedge tck or negedge test_reset_n)
  begin
    if (!test_reset_n)
      state <= TAP_RESET;
    else
      state <= next_state;
  end

  five_ones_a: assert property (
    @(posedge tck) disable iff (!test_reset_n)
    tms [*5] |=> state == TAP_RESET)
    else $error("five tms ones did not reach reset state");

  idle_entry_a: assert property (
    @(posedge tck) disable iff (!test_reset_n)
    (state == TAP_RESET || state == TAP_UPDATE_DR) && !tms |=> state == TAP_IDLE)
    else $error("tms low did not enter idle");

endmodule

// File: test/scan_ctrl_model.sv
// scan controller model: drives test clock, mode select and data in
module scan_ctrl_model (
  output logic tck, // test clock, still between frames
  output logic tms, // mode select
  output logic tdi, // data in, parked high like its pull-up
  input wire logic tdo, // data out from the port
  input wire logic tdo_oe // high while the port drives tdo
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end

  // one 30 ns period; tdo is taken just before the rising edge it shifts on
  task automatic step(input logic m, input logic d, output logic q, output logic oe);
    tms = m;
    tdi = d;
    #15;
    // an undriven tdo reads inverted so a missing drive shows up
    q = (tdo_oe === 1'b1) ? tdo : !tdo;
    oe = tdo_oe;
    tck = 1'b1;
    #15;
    tck = 1'b0;
  endtask

  task automatic idle(input int n);
    logic q;
    logic oe;
    repeat (n) step(1'b0, 1'b1, q, oe);
  endtask

  task automatic reset_tap();
    logic q;
    logic oe;
    repeat (5) step(1'b1, 1'b1, q, oe);
    step(1'b0, 1'b1, q, oe);
  endtask

  // from idle: shift n bits lsb first through ir or dr, then back to idle
  task automatic scan(input logic is_ir, input logic [31:0] din, input int n,
    output logic [31:0] dout, output int oe_cnt);
    logic q;
    logic oe;
    dout = '0;
    oe_cnt = 0;
    step(1'b1, 1'b1, q, oe);
    if (is_ir)
      step(1'b1, 1'b1, q, oe);
    step(1'b0, 1'b1, q, oe);
    step(1'b0, 1'b1, q, oe);
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, din[i], q, oe);
      dout[i] = q;
      oe_cnt += (oe === 1'b1);
    end
    step(1'b1, 1'b1, q, oe);
    step(1'b0, 1'b1, q, oe);
  endtask
endmodule

// File: test/test_scan_test_port.sv
// testbench for the scan test port and output-disable logic
module test_scan_test_port
  import scan_port_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic test_reset_n = 1'b1;
  logic emu_irq_req = 1'b0;
  logic emulator_pin_zero_drv = 1'b1;
  logic emu1_drv = 1'b1;
  logic tck, tms, tdi, tdo, tdo_oe;
  logic p0_o, p0_oe, p1_o, p1_oe, pin0, pin1;
  logic scan_mode, all_outputs_float, emulator_pin_zero_irq, emu1_irq;
  logic [31:0] d;
  int n;
  int error_cnt = 0;
  int check_count = 0;

  always #12.5 clk = ~clk;

  // wire level: whoever enables drives, otherwise the emulator side
  assign pin0 = p0_oe ? p0_o : emulator_pin_zero_drv;
  assign pin1 = p1_oe ? p1_o : emu1_drv;

  scan_ctrl_model m (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));

  scan_test_port dut (
    .clk(clk), .sys_rst(sys_rst), .tck(tck), .test_reset_n(test_reset_n),
    .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
    .emulator_pin_zero_i(pin0), .emulator_pin_zero_o(p0_o),
    .emulator_pin_zero_oe(p0_oe), .emulator_pin_one_output_disable_i(pin1),
    .emulator_pin_one_output_disable_o(p1_o),
    .emulator_pin_one_output_disable_oe(p1_oe), .emu_irq_req(emu_irq_req),
    .scan_mode(scan_mode), .all_outputs_float(all_outputs_float),
    .emulator_pin_zero_irq(emulator_pin_zero_irq), .emu1_irq(emu1_irq)
  );

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // pin levels change at a clock edge, then settle through the synchronisers
  task automatic pins(input logic t, input logic e0, input logic e1);
    @(posedge clk);
    test_reset_n <= t;
    emulator_pin_zero_drv <= e0;
    emu1_drv <= e1;
    repeat (6) @(posedge clk);
    #1;
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // output-disable used only as a test condition here
  task automatic test_off();
    pins(1'b0, 1'b1, 1'b0);
    check(all_outputs_float, 1'b1);
    check(scan_mode, 1'b0);
    check(tdo_oe, 1'b0);
    m.reset_tap();
    m.scan(1'b1, 32'(IR_IDCODE), IR_WIDTH, d, n);
    check(n, 0);
    pins(1'b0, 1'b0, 1'b0);
    check(all_outputs_float, 1'b0);
    pins(1'b0, 1'b1, 1'b1);
    check(all_outputs_float, 1'b0);
    $display("test off done");
  endtask

  task automatic test_idcode();
    pins(1'b1, 1'b1, 1'b0);
    check(scan_mode, 1'b1);
    check(all_outputs_float, 1'b0);
    m.reset_tap();
    m.scan(1'b1, 32'(IR_IDCODE), IR_WIDTH, d, n);
    check(d[3:0], IR_CAPTURE_PATTERN);
    check(n, IR_WIDTH);
    m.scan(1'b0, 32'h0000_0000, DR_WIDTH, d, n);
    check(d, ID_VALUE_DEFAULT);
    check(n, DR_WIDTH);
    m.idle(1);
    #1;
    check(tdo_oe, 1'b0);
    $display("test idcode done");
  endtask

  // bypass delays tdi by one bit and captures zero first
  task automatic test_bypass();
    m.scan(1'b1, 32'(IR_BYPASS), IR_WIDTH, d, n);
    m.scan(1'b0, 32'h0000_00a5, 8, d, n);
    check(d[7:0], 8'h4a);
    check(n, 8);
    $display("test bypass done");
  endtask

  task automatic test_emu();
    m.scan(1'b1, 32'(IR_EMU_CTRL), IR_WIDTH, d, n);
    m.scan(1'b0, 32'h0000_0007, EMU_CTRL_WIDTH, d, n);
    m.idle(1);
    check({p0_oe, p0_o, p1_oe, p1_o}, 4'he);
    @(posedge clk);
    emu_irq_req <= 1'b1;
    m.idle(4);
    check(p1_o, 1'b1);
    @(posedge clk);
    emu_irq_req <= 1'b0;
    m.scan(1'b0, 32'h0000_0000, EMU_CTRL_WIDTH, d, n);
    check(d[2:0], 3'b111);
    m.idle(1);
    check({p0_oe, p1_oe}, 2'b00);
    m.scan(1'b0, 32'h0000_0003, EMU_CTRL_WIDTH, d, n);
    m.idle(1);
    check({p0_oe, p1_oe}, 2'b11);
    @(posedge clk);
    test_reset_n <= 1'b0;
    @(posedge clk);
    #1;
    check({p0_oe, p1_oe, tdo_oe}, 3'b000);
    pins(1'b1, 1'b1, 1'b0);
    check({emulator_pin_zero_irq, emu1_irq}, 2'b10);
    $display("test emu done");
  endtask

  // test reset goes low at start and stays low until test_idcode, so the tck-side flops leave unknown
  initial
  begin
    @(posedge clk);
    test_reset_n <= 1'b0;
    repeat (11) @(posedge clk);
    sys_rst <= 1'b0;
    test_off();
    test_idcode();
    test_bypass();
    test_emu();
    final_report();
  end

  initial
  begin
    #1_000_000;
    error_cnt++;
    final_report();
  end
endmodule
